// ==== rtl/blank_if.sv ====
`timescale 1ns/1ps
interface blank_if;
    logic start;
    logic active;
    modport ctrl (output start, input active);
    modport timer (input start, output active);
endinterface : blank_if

// ==== rtl/blank_timer.sv ====
`timescale 1ns/1ps
module blank_timer #(
    parameter int BLANK_CYCLES = buck2_pkg::BLANK_CYCLES
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ce,
    blank_if.timer bus
);

    localparam int CNT_W = buck2_pkg::BLANK_CNT_W;
    localparam logic [CNT_W-1:0] LOAD = CNT_W'(BLANK_CYCLES - 1);

    buck2_pkg::blank_state_type state_r, state_nxt;
    logic [buck2_pkg::BLANK_CNT_W-1:0] count_r, count_nxt;

    // ========================================================
    // blanking countdown, restarted by every accepted write
    always_comb begin
        state_nxt = state_r;
        count_nxt = count_r;
        if (bus.start) begin
            state_nxt = buck2_pkg::BLANK_RUN;
            count_nxt = LOAD;
        end else begin
            case (state_r)
                buck2_pkg::BLANK_IDLE: begin
                    count_nxt = '0;
                end
                buck2_pkg::BLANK_RUN: begin
                    if (count_r == '0) begin
                        state_nxt = buck2_pkg::BLANK_IDLE;
                    end else begin
                        count_nxt = count_r - 1'b1;
                    end
                end
                default: begin
                    state_nxt = buck2_pkg::BLANK_IDLE;
                    count_nxt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_r <= buck2_pkg::BLANK_IDLE;
            count_r <= '0;
        end else if (ce) begin
            state_r <= state_nxt;
            count_r <= count_nxt;
        end
    end

    assign bus.active = (state_r == buck2_pkg::BLANK_RUN);

endmodule : blank_timer

// ==== rtl/buck2_output_control_reg.sv ====
// Summary of operation
// - register lives at subaddress 17h and resets to 99h.
// - writes are taken only while the password unlock is granted.
// - any accepted write blanks over/under-voltage faults for 5 ms.
// - new voltage code applies only on apply or alternate apply trigger.
// - bit 7 enables light-load pulse skipping, resets to one.
// - bits 5..0 voltage code, default loaded from non-volatile storage.
// - codes 0-32h give 850 mV + 10 mV steps, then 1375 mV + 25 mV.
`timescale 1ns/1ps
module buck2_output_control_reg #(
    parameter int BLANK_CYCLES = buck2_pkg::BLANK_CYCLES
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] subaddr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic rd_valid,
    output logic write_rejected,
    input wire logic write_unlocked,
    input wire logic apply_trigger,
    input wire logic alternate_apply_trigger,
    input wire logic [5:0] nonvolatile_backed_default,
    input wire logic ov_detect,
    input wire logic uv_detect,
    output logic ov_fault,
    output logic uv_fault,
    output logic light_load_pulse_skip_enable,
    output logic [5:0] buck2_voltage_code,
    output logic [10:0] applied_millivolts
);

    blank_if blank ();

    blank_timer #(
        .BLANK_CYCLES(BLANK_CYCLES)
    ) u_blank (
        .mclk(mclk),
        .resetn(resetn),
        .ce(ce),
        .bus(blank.timer)
    );

    // ========================================================
    // write decode
    logic hit;
    logic wr_accept;

    assign hit = (subaddr == buck2_pkg::CTRL_SUBADDR);
    assign wr_accept = ce && wr_en && hit && write_unlocked;
    assign write_rejected = ce && wr_en && hit && !write_unlocked;
    assign blank.start = wr_accept;

    // ========================================================
    // register fields and applied setting
    logic pskip_r, pskip_nxt;
    logic [5:0] code_r, code_nxt;
    logic [5:0] applied_r, applied_nxt;
    logic [10:0] mv_r, mv_nxt;

    always_comb begin
        pskip_nxt = pskip_r;
        code_nxt = code_r;
        applied_nxt = applied_r;
        if (wr_accept) begin
            pskip_nxt = wdata[buck2_pkg::PSKIP_BIT];
            code_nxt = wdata[buck2_pkg::CODE_MSB:buck2_pkg::CODE_LSB];
        end
        if (apply_trigger || alternate_apply_trigger) begin
            applied_nxt = code_r;
        end
        mv_nxt = buck2_pkg::code_to_mv(applied_nxt);
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pskip_r <= buck2_pkg::PSKIP_RESET;
            code_r <= nonvolatile_backed_default;
            applied_r <= nonvolatile_backed_default;
            mv_r <= buck2_pkg::code_to_mv(nonvolatile_backed_default);
        end else if (ce) begin
            pskip_r <= pskip_nxt;
            code_r <= code_nxt;
            applied_r <= applied_nxt;
            mv_r <= mv_nxt;
        end
    end

    assign light_load_pulse_skip_enable = pskip_r;
    assign buck2_voltage_code = applied_r;
    assign applied_millivolts = mv_r;

    // ========================================================
    // read port
    logic [7:0] rdata_r, rdata_nxt;
    logic rd_valid_r, rd_valid_nxt;

    always_comb begin
        rd_valid_nxt = ce && rd_en;
        rdata_nxt = 8'h00;
        if (rd_en && hit) begin
            rdata_nxt = {pskip_r, 1'b0, code_r};
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rdata_r <= 8'h00;
            rd_valid_r <= 1'b0;
        end else if (ce) begin
            rdata_r <= rdata_nxt;
            rd_valid_r <= rd_valid_nxt;
        end
    end

    assign rdata = rdata_r;
    assign rd_valid = rd_valid_r;

    // ========================================================
    // fault monitoring, masked during blanking
    logic ov_r, ov_nxt;
    logic uv_r, uv_nxt;

    always_comb begin
        ov_nxt = ov_detect && !blank.active && !wr_accept;
        uv_nxt = uv_detect && !blank.active && !wr_accept;
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ov_r <= 1'b0;
            uv_r <= 1'b0;
        end else if (ce) begin
            ov_r <= ov_nxt;
            uv_r <= uv_nxt;
        end
    end

    assign ov_fault = ov_r;
    assign uv_fault = uv_r;

    // ========================================================
    // checks
    reset_value_a: assert property (
        @(posedge mclk) (!resetn && nonvolatile_backed_default
            == buck2_pkg::CODE_DEFAULT) |=>
            ({pskip_r, 1'b0, code_r} == buck2_pkg::CTRL_RESET))
        else $error("reset value not 99h");

    locked_write_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        (wr_en && hit && !write_unlocked && !apply_trigger
            && !alternate_apply_trigger) |=>
            ($stable(code_r) && $stable(pskip_r)))
        else $error("locked write changed register");

    blank_start_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        wr_accept |=> blank.active [*8])
        else $error("blanking did not start on write");

    fault_mask_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        (ce && blank.active) |=> (!ov_fault && !uv_fault))
        else $error("fault reported during blanking");

    apply_hold_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        (!apply_trigger && !alternate_apply_trigger)
            |=> $stable(buck2_voltage_code))
        else $error("voltage changed without trigger");

    apply_take_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        (ce && (apply_trigger || alternate_apply_trigger))
            |=> (buck2_voltage_code == $past(code_r)))
        else $error("trigger did not apply code");

    pskip_write_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        wr_accept |=> (light_load_pulse_skip_enable == $past(wdata[7])))
        else $error("pulse skip bit not written");

    code_readback_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        (wr_accept ##1 (ce && rd_en && hit && !wr_en))
            |=> (rdata[5:0] == $past(wdata[5:0], 2)))
        else $error("code readback mismatch");

    voltage_map_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        (buck2_voltage_code == 6'h33 |-> applied_millivolts == 11'h55F)
        and (buck2_voltage_code == 6'h32 |-> applied_millivolts == 11'h546)
        and (buck2_voltage_code == 6'h3F |-> applied_millivolts == 11'h68B))
        else $error("voltage table mismatch");

    reserved_zero_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        rd_valid |-> (rdata[buck2_pkg::RSVD_BIT] == 1'b0))
        else $error("reserved bit reads one");

    rd_valid_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        ce |=> (rd_valid == $past(rd_en)))
        else $error("read valid not one cycle after request");

    unmapped_zero_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        (ce && rd_en && !hit) |=> (rdata == 8'h00))
        else $error("unmapped read not zero");

    rejected_no_blank_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        (write_rejected && !blank.active) |=> !blank.active)
        else $error("rejected write started blanking");

    fault_follow_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        (ce && !blank.active && !wr_accept) |=>
            ((ov_fault == $past(ov_detect))
            && (uv_fault == $past(uv_detect))))
        else $error("fault not reported outside blanking");

    field_hold_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        (ce && !wr_accept) |=> ($stable(code_r) && $stable(pskip_r)))
        else $error("register changed without write");

endmodule : buck2_output_control_reg

// ==== rtl/buck2_pkg.sv ====
package buck2_pkg;

    // ========================================================
    // register map
    localparam logic [7:0] CTRL_SUBADDR = 8'h17;
    localparam logic [7:0] CTRL_RESET = 8'h99;
    localparam int PSKIP_BIT = 7;
    localparam int RSVD_BIT = 6;
    localparam int CODE_MSB = 5;
    localparam int CODE_LSB = 0;
    localparam logic PSKIP_RESET = 1'b1;
    localparam logic [5:0] CODE_DEFAULT = 6'h19;

    // ========================================================
    // voltage table
    localparam logic [5:0] CODE_FINE_LAST = 6'h32;
    localparam logic [5:0] CODE_COARSE_FIRST = 6'h33;
    localparam logic [10:0] FINE_BASE_MV = 11'h352;
    localparam logic [10:0] FINE_STEP_MV = 11'h00A;
    localparam logic [10:0] COARSE_BASE_MV = 11'h55F;
    localparam logic [10:0] COARSE_STEP_MV = 11'h019;

    // ========================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int BLANK_TIME_MS = 5;
    localparam int BLANK_CYCLES =
        BLANK_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int BLANK_CNT_W = 20;

    typedef enum logic [0:0] {
        BLANK_IDLE = 1'b0,
        BLANK_RUN = 1'b1
    } blank_state_type;

    // code to output millivolts
    function automatic logic [10:0] code_to_mv(input logic [5:0] code);
        logic [10:0] c;
        c = {5'h00, code};
        if (code <= CODE_FINE_LAST) begin
            code_to_mv = 11'(FINE_BASE_MV + c * FINE_STEP_MV);
        end else begin
            code_to_mv = 11'(COARSE_BASE_MV
                + (c - {5'h00, CODE_COARSE_FIRST}) * COARSE_STEP_MV);
        end
    endfunction : code_to_mv

endpackage : buck2_pkg

// ==== verification/host_model.sv ====
`timescale 1ns/1ps
// ========================================================
// host side: register requests and apply triggers
module host_model (
    input wire logic mclk,
    input wire logic [7:0] rdata,
    input wire logic rd_valid,
    input wire logic write_rejected,
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] subaddr,
    output logic [7:0] wdata,
    output logic write_unlocked,
    output logic apply_trigger,
    output logic alternate_apply_trigger
);
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        subaddr = 8'h00;
        wdata = 8'h00;
        write_unlocked = 1'b0;
        apply_trigger = 1'b0;
        alternate_apply_trigger = 1'b0;
    end

    // unlock is granted in the same cycle as the write, for that one write only
    task automatic do_write(input logic [7:0] a, input logic [7:0] d,
                            input logic unlock, output logic rej);
        @(posedge mclk);
        write_unlocked <= unlock;
        wr_en <= 1'b1;
        subaddr <= a;
        wdata <= d;
        #1 rej = write_rejected;
        @(posedge mclk);
        wr_en <= 1'b0;
        write_unlocked <= 1'b0;
        subaddr <= ~a;
        wdata <= ~d;
    endtask : do_write

    task automatic do_read(input logic [7:0] a, output logic [7:0] d,
                           output logic v);
        @(posedge mclk);
        rd_en <= 1'b1;
        subaddr <= a;
        @(posedge mclk);
        rd_en <= 1'b0;
        subaddr <= ~a;
        #1 d = rdata;
        v = rd_valid;
    endtask : do_read

    // write, then read the same subaddress on the very next edge
    task automatic do_write_read(input logic [7:0] a, input logic [7:0] d,
                                 output logic [7:0] q);
        @(posedge mclk);
        write_unlocked <= 1'b1;
        wr_en <= 1'b1;
        subaddr <= a;
        wdata <= d;
        @(posedge mclk);
        wr_en <= 1'b0;
        write_unlocked <= 1'b0;
        rd_en <= 1'b1;
        wdata <= ~d;
        @(posedge mclk);
        rd_en <= 1'b0;
        subaddr <= ~a;
        #1 q = rdata;
    endtask : do_write_read

    task automatic do_apply(input logic alt);
        @(posedge mclk);
        apply_trigger <= ~alt;
        alternate_apply_trigger <= alt;
        @(posedge mclk);
        apply_trigger <= 1'b0;
        alternate_apply_trigger <= 1'b0;
    endtask : do_apply
endmodule : host_model

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    localparam int BLANK_SIM = 16;
    logic mclk;
    logic resetn;
    logic ce;
    logic ov_detect;
    logic uv_detect;
    logic [5:0] nv_code;
    logic wr_en, rd_en, unlocked, apply, alt_apply;
    logic [7:0] subaddr, wdata, rdata;
    logic rd_valid, rejected, ov_fault, uv_fault, pskip;
    logic [5:0] code;
    logic [10:0] mv;
    logic [31:0] rng = 32'h0000E14C;
    logic [7:0] m_reg;
    logic [5:0] m_app;
    logic [7:0] exp_q [$];
    logic [5:0] edge_codes [4] = '{6'h00, 6'h32, 6'h33, 6'h3F};
    int errors = 0;
    int checks_done = 0;

    buck2_output_control_reg #(.BLANK_CYCLES(BLANK_SIM)) uut (
        .mclk(mclk), .resetn(resetn), .ce(ce), .wr_en(wr_en),
        .rd_en(rd_en), .subaddr(subaddr), .wdata(wdata), .rdata(rdata),
        .rd_valid(rd_valid), .write_rejected(rejected),
        .write_unlocked(unlocked), .apply_trigger(apply),
        .alternate_apply_trigger(alt_apply),
        .nonvolatile_backed_default(nv_code), .ov_detect(ov_detect),
        .uv_detect(uv_detect), .ov_fault(ov_fault), .uv_fault(uv_fault),
        .light_load_pulse_skip_enable(pskip),
        .buck2_voltage_code(code), .applied_millivolts(mv));

    host_model host (
        .mclk(mclk), .rdata(rdata), .rd_valid(rd_valid),
        .write_rejected(rejected), .wr_en(wr_en), .rd_en(rd_en),
        .subaddr(subaddr), .wdata(wdata), .write_unlocked(unlocked),
        .apply_trigger(apply), .alternate_apply_trigger(alt_apply));

    // ========================================================
    // helpers
    function automatic logic [31:0] xorshift();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xorshift

    function automatic int mv_of(input int c);
        return (c <= 50) ? 850 + 10 * c : 1375 + 25 * (c - 51);
    endfunction : mv_of

    task automatic tally(input logic good, input logic [15:0] got,
                         input logic [15:0] exp);
        checks_done++;
        if (!good) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : tally

    // read data against the oldest expected read of the model
    task automatic chk_read(input logic [7:0] got);
        logic [7:0] exp;
        exp = exp_q.pop_front();
        tally(got === exp, {8'h00, got}, {8'h00, exp});
    endtask : chk_read

    task automatic chk_flag(input logic got, input logic exp);
        tally(got === exp, {15'h0000, got}, {15'h0000, exp});
    endtask : chk_flag

    task automatic chk_code(input logic [5:0] got, input logic [5:0] exp);
        tally(got === exp, {10'h000, got}, {10'h000, exp});
    endtask : chk_code

    task automatic chk_mv(input logic [10:0] got, input int exp);
        tally(got === 11'(exp), {5'h00, got}, 16'(exp));
    endtask : chk_mv

    task automatic give_verdict();
        $display("checks=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict

    task automatic do_reset(input logic [5:0] nv);
        logic [7:0] d;
        logic v;
        resetn <= 1'b0;
        nv_code <= nv;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        m_reg = {2'b10, nv};
        m_app = nv;
        exp_q.push_back(m_reg);
        host.do_read(8'h17, d, v);
        chk_flag(v, 1'b1);
        chk_read(d);
        chk_flag(pskip, 1'b1);
        chk_code(code, nv);
        chk_mv(mv, mv_of(nv));
        $display("test reset done");
    endtask : do_reset

    // ========================================================
    // clock and watchdog
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        #100000;
        errors++;
        give_verdict();
    end

    // ========================================================
    // tests
    initial begin : main
        logic [7:0] d;
        logic v;
        logic rej;
        logic [31:0] r;
        resetn = 1'b0;
        ce = 1'b1;
        ov_detect = 1'b0;
        uv_detect = 1'b0;
        nv_code = 6'h19;
        do_reset(6'h19);
        host.do_write(8'h17, 8'h00, 1'b0, rej);
        chk_flag(rej, 1'b1);
        host.do_write(8'h18, 8'h00, 1'b1, rej);
        chk_flag(rej, 1'b0);
        exp_q.push_back(8'h00);
        host.do_read(8'h18, d, v);
        chk_read(d);
        chk_flag(v, 1'b1);
        exp_q.push_back(m_reg);
        host.do_read(8'h17, d, v);
        chk_read(d);
        $display("test lock done");
        for (int i = 0; i < 12; i++) begin
            r = xorshift();
            d = r[7:0];
            if (i < 4) begin
                d[5:0] = edge_codes[i];
            end
            host.do_write(8'h17, d, 1'b1, rej);
            chk_flag(rej, 1'b0);
            m_reg = d & 8'hBF;
            exp_q.push_back(m_reg);
            host.do_read(8'h17, d, v);
            chk_read(d);
            chk_flag(pskip, m_reg[7]);
            chk_code(code, m_app);
            host.do_apply(i[0]);
            m_app = m_reg[5:0];
            #1 chk_code(code, m_app);
            chk_mv(mv, mv_of(m_app));
        end
        $display("test random done");
        r = xorshift();
        m_reg = r[7:0] & 8'hBF;
        exp_q.push_back(m_reg);
        host.do_write_read(8'h17, r[7:0], d);
        chk_read(d);
        $display("test back to back done");
        host.do_write(8'h17, 8'h99, 1'b1, rej);
        chk_flag(rej, 1'b0);
        m_reg = 8'h99;
        ov_detect <= 1'b1;
        uv_detect <= 1'b1;
        // last masked cycle, then the first reported one
        repeat (BLANK_SIM) @(posedge mclk);
        #1 chk_flag(ov_fault, 1'b0);
        chk_flag(uv_fault, 1'b0);
        @(posedge mclk);
        #1 chk_flag(ov_fault, 1'b1);
        chk_flag(uv_fault, 1'b1);
        @(posedge mclk);
        ov_detect <= 1'b0;
        uv_detect <= 1'b0;
        $display("test blanking done");
        ce <= 1'b0;
        host.do_apply(1'b0);
        #1 chk_code(code, m_app);
        @(posedge mclk);
        ce <= 1'b1;
        host.do_apply(1'b1);
        m_app = m_reg[5:0];
        #1 chk_code(code, m_app);
        chk_mv(mv, mv_of(m_app));
        $display("test enable done");
        r = xorshift();
        @(posedge mclk);
        do_reset(r[5:0]);
        give_verdict();
    end
endmodule : tb_top
